/* hw/lrc_params.svh */
// lrc_params.svh: register offsets, field positions and reset values of the check block
// assumes: included by bare name from the residue, counter and checker design files; the package does not include it
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH
`define LRC_OFS_CONFIG   5'h00
`define LRC_OFS_RATIO    5'h04
`define LRC_OFS_BLKSIZE  5'h08
`define LRC_OFS_RESIDUE  5'h0c
`define LRC_OFS_CONTROL  5'h10
`define LRC_OFS_STATUS   5'h14
`define LRC_OFS_DPRESET  5'h18
`define LRC_OFS_TCOUNT   5'h1c
`define LRC_CFG_GEN      0
`define LRC_CFG_CCE      1
`define LRC_CFG_BCM      2
`define LRC_CTL_LD       0
`define LRC_CTL_LDL      1
`define LRC_STS_MIS      0
`define LRC_STS_DMIS     1
`define LRC_STS_BUSY     2
`define LRC_STS_HALT     3
`define LRC_SEED         16'haaaa
`define LRC_RATIO_RST    8'h00
`define LRC_BLKSIZE_RST  16'h01ff
`define LRC_CFG_RST      3'h0
`endif

/* hw/lrc_pkg.sv */
// lrc_pkg: types shared by the check block
// assumes: nothing beyond the compiler
package lrc_pkg;
    typedef enum logic [2:0] {
        st_idle   = 3'b000,
        st_xfer   = 3'b001,
        st_insert = 3'b010,
        st_strip  = 3'b011,
        st_halt   = 3'b100
    } lrc_state_type;
endpackage : lrc_pkg

/* hw/lrc_residue.sv */
// lrc_residue: running xor residue with reseed and software load
// assumes: controls come from logic on the same clock
`include "lrc_params.svh"
module lrc_residue
    import lrc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic         seed_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         xor_i,
    input  wire logic [W-1:0] word_i,
    output logic      [W-1:0] value_o
);
    logic [W-1:0] res_q;
    logic [W-1:0] res_d;

    always_comb begin
        res_d = res_q;
        if (seed_i) begin
            res_d = W'(`LRC_SEED);
        end else if (load_i) begin
            res_d = load_val_i;
        end else if (xor_i) begin
            res_d = res_q ^ word_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            res_q <= W'(`LRC_SEED);
        end else begin
            res_q <= res_d;
        end
    end

    assign value_o = res_q;

    chk_xor_accumulate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (xor_i && !seed_i && !load_i) |=> res_q == ($past(res_q) ^ $past(word_i)))
        else $error("residue did not take the xor of the word");
endmodule : lrc_residue

/* hw/lrc_block_counter.sv */
// lrc_block_counter: words within a physical block, physical blocks within a logical block
// assumes: block size in bytes minus one and odd, ratio high nibble = first span minus one
`include "lrc_params.svh"
module lrc_block_counter
    import lrc_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        clear_i,
    input  wire logic        start_i,
    input  wire logic        step_i,
    input  wire logic [15:0] blk_size_i,
    input  wire logic [7:0]  ratio_i,
    output logic             blk_last_o,
    output logic             log_last_o
);
    logic [14:0] word_q;
    logic [14:0] word_d;
    logic [3:0]  phys_q;
    logic [3:0]  phys_d;

    always_comb begin
        word_d = word_q;
        phys_d = phys_q;
        if (clear_i) begin
            word_d = 15'h0000;
            phys_d = ratio_i[3:0];
        end else if (start_i) begin
            word_d = 15'h0000;
            phys_d = ratio_i[7:4];
        end else if (step_i) begin
            if (blk_last_o) begin
                word_d = 15'h0000;
                phys_d = log_last_o ? ratio_i[3:0] : phys_q - 4'h1;
            end else begin
                word_d = word_q + 15'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_q <= 15'h0000;
            phys_q <= 4'h0;
        end else begin
            word_q <= word_d;
            phys_q <= phys_d;
        end
    end

    assign blk_last_o = (word_q == blk_size_i[15:1]);
    assign log_last_o = (phys_q == 4'h0);

    chk_logical_reload: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (step_i && !clear_i && !start_i && blk_last_o && log_last_o)
        |=> phys_q == $past(ratio_i[3:0]) && word_q == 15'h0000)
        else $error("logical block did not reload the ratio");
endmodule : lrc_block_counter

/* hw/lrc_block_checker.sv */
// lrc_block_checker: check word generation, stripping and disk-side checking with avalon registers
// assumes: one clock; scsi, fifo and disk ports are driven by logic on this clock; 16-bit words
// Function
// - residue is xor of every data word while generate bit is high
// - make check word in, check it out
// - disk writes check word at sector boundary
// - disk residue reseeds to aaaa per logical block
// - preset residue and starting physical block honoured
// - block ratio resets to zero
// - ratio codes select covered trailing blocks
// - both load bits together clear pipeline
// - transfer start reseeds unless residue was written
// - receive updates residue before fifo, ignores compare
// - push check word per block, reseed logically
// - generate bit low: no update, strip, compare
// - generate bit high: update on sent words
// - pop check word, compare, reseed at logical
// - compare mismatch sets flag and halts
`include "lrc_params.svh"
module lrc_block_checker
    import lrc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [4:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [31:0]  avs_writedata_i,
    output logic      [31:0]  avs_readdata_o,
    output logic              avs_waitrequest_o,
    input  wire logic         xfer_start_i,
    input  wire logic         xfer_dir_i,
    input  wire logic         xfer_stop_i,
    output logic              xfer_busy_o,
    output logic              xfer_halted_o,
    input  wire logic         scsi_rx_valid_i,
    input  wire logic [W-1:0] scsi_rx_data_i,
    output logic              scsi_rx_ready_o,
    output logic              fifo_wr_valid_o,
    output logic      [W-1:0] fifo_wr_data_o,
    input  wire logic         fifo_wr_ready_i,
    input  wire logic         fifo_rd_valid_i,
    input  wire logic [W-1:0] fifo_rd_data_i,
    output logic              fifo_rd_ready_o,
    output logic              scsi_tx_valid_o,
    output logic      [W-1:0] scsi_tx_data_o,
    input  wire logic         scsi_tx_ready_i,
    input  wire logic         disk_start_i,
    input  wire logic         disk_valid_i,
    input  wire logic [W-1:0] disk_data_i,
    output logic              disk_mismatch_o
);
    ////////////////////////////////////////////////////////////////////////
    // avalon slave and configuration
    logic          ack_q, ack_d;
    logic [31:0]   rdata_q, rdata_d;
    logic [2:0]    cfg_q, cfg_d;
    logic [7:0]    ratio_q, ratio_d;
    logic [15:0]   blksize_q, blksize_d;
    logic [W-1:0]  dpreset_q, dpreset_d;
    logic          mis_q, mis_d, dmis_q, dmis_d;
    logic          wr, mis_set, dmis_set, pipe_clear, sw_res_load;
    lrc_state_type state_q, state_d;
    logic [15:0]   tc_q, tc_d;
    logic [W-1:0]  res;
    logic [W-1:0]  dres;

    // one wait cycle per access: read data are latched in it and stand when waitrequest drops
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign wr = avs_write_i && ack_q;
    assign pipe_clear = wr && avs_address_i == `LRC_OFS_CONTROL
                        && avs_writedata_i[`LRC_CTL_LD] && avs_writedata_i[`LRC_CTL_LDL];
    assign sw_res_load = wr && avs_address_i == `LRC_OFS_RESIDUE;

    always_comb begin
        ack_d     = (avs_read_i || avs_write_i) && !ack_q;
        rdata_d   = rdata_q;
        cfg_d     = cfg_q;
        ratio_d   = ratio_q;
        blksize_d = blksize_q;
        dpreset_d = dpreset_q;
        mis_d     = mis_q;
        dmis_d    = dmis_q;
        if (avs_read_i && !ack_q) begin
            unique case (avs_address_i)
                `LRC_OFS_CONFIG:  rdata_d = {29'h0, cfg_q};
                `LRC_OFS_RATIO:   rdata_d = {24'h0, ratio_q};
                `LRC_OFS_BLKSIZE: rdata_d = {16'h0, blksize_q};
                `LRC_OFS_RESIDUE: rdata_d = 32'(res);
                `LRC_OFS_STATUS:  rdata_d = {28'h0, state_q == st_halt, state_q != st_idle, dmis_q, mis_q};
                `LRC_OFS_DPRESET: rdata_d = 32'(dpreset_q);
                `LRC_OFS_TCOUNT:  rdata_d = {16'h0, tc_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (avs_address_i)
                `LRC_OFS_CONFIG:  cfg_d = avs_writedata_i[2:0];
                `LRC_OFS_RATIO:   ratio_d = avs_writedata_i[7:0];
                `LRC_OFS_BLKSIZE: blksize_d = avs_writedata_i[15:0];
                `LRC_OFS_DPRESET: dpreset_d = avs_writedata_i[W-1:0];
                `LRC_OFS_STATUS: begin
                    mis_d  = mis_q && !avs_writedata_i[`LRC_STS_MIS];
                    dmis_d = dmis_q && !avs_writedata_i[`LRC_STS_DMIS];
                end
                default: ;
            endcase
        end
        // a hardware event wins over a clear in the same cycle
        if (mis_set) begin
            mis_d = 1'b1;
        end
        if (dmis_set) begin
            dmis_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q     <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            cfg_q     <= `LRC_CFG_RST;
            ratio_q   <= `LRC_RATIO_RST;
            blksize_q <= `LRC_BLKSIZE_RST;
            dpreset_q <= W'(`LRC_SEED);
            mis_q     <= 1'b0;
            dmis_q    <= 1'b0;
        end else begin
            ack_q     <= ack_d;
            rdata_q   <= rdata_d;
            cfg_q     <= cfg_d;
            ratio_q   <= ratio_d;
            blksize_q <= blksize_d;
            dpreset_q <= dpreset_d;
            mis_q     <= mis_d;
            dmis_q    <= dmis_d;
        end
    end

    assign avs_readdata_o  = rdata_q;
    assign disk_mismatch_o = dmis_q;

    ////////////////////////////////////////////////////////////////////////
    // scsi transfer engine: one output stage shared by both directions
    logic         dir_q, dir_d, out_v_q, out_v_d, log_q, log_d, preset_q, preset_d;
    logic [W-1:0] out_data_q, out_data_d;
    logic         in_valid, in_ready, in_fire, out_ready, can_load;
    logic [W-1:0] in_data;
    logic         res_seed, res_xor, cnt_start, cnt_step, blk_last, log_last, tc_dec;
    logic         gen, cce, bcm;

    assign gen       = cfg_q[`LRC_CFG_GEN];
    assign cce       = cfg_q[`LRC_CFG_CCE];
    assign bcm       = cfg_q[`LRC_CFG_BCM];
    assign in_valid  = dir_q ? fifo_rd_valid_i : scsi_rx_valid_i;
    assign in_data   = dir_q ? fifo_rd_data_i : scsi_rx_data_i;
    assign out_ready = dir_q ? scsi_tx_ready_i : fifo_wr_ready_i;
    assign can_load  = !out_v_q || out_ready;
    // the stripped word is popped with no output slot needed
    assign in_ready  = (state_q == st_xfer && can_load) || state_q == st_strip;
    assign in_fire   = in_valid && in_ready;

    always_comb begin
        state_d    = state_q;
        dir_d      = dir_q;
        out_v_d    = out_v_q && !out_ready;
        out_data_d = out_data_q;
        log_d      = log_q;
        preset_d   = preset_q;
        tc_d       = tc_q;
        res_seed   = 1'b0;
        res_xor    = 1'b0;
        cnt_start  = 1'b0;
        cnt_step   = 1'b0;
        tc_dec     = 1'b0;
        mis_set    = 1'b0;
        unique case (state_q)
            st_idle: begin
                if (xfer_start_i) begin
                    state_d   = st_xfer;
                    dir_d     = xfer_dir_i;
                    cnt_start = 1'b1;
                    res_seed  = !preset_q;
                    preset_d  = 1'b0;
                end
            end
            st_xfer: begin
                if (in_fire) begin
                    out_v_d    = 1'b1;
                    out_data_d = in_data;
                    if (gen) begin
                        res_xor  = 1'b1;
                        cnt_step = 1'b1;
                        if (blk_last) begin
                            log_d   = log_last;
                            state_d = dir_q ? st_strip : st_insert;
                        end
                    end
                end
            end
            st_insert: begin
                if (can_load) begin
                    out_v_d    = 1'b1;
                    out_data_d = res;
                    res_seed   = log_q;
                    tc_dec     = log_q;
                    state_d    = st_xfer;
                end
            end
            st_strip: begin
                if (in_fire) begin
                    if (cce && in_data != res) begin
                        mis_set = 1'b1;
                        state_d = st_halt;
                    end else begin
                        res_seed = log_q;
                        tc_dec   = log_q;
                        state_d  = st_xfer;
                    end
                end
            end
            st_halt: ;
        endcase
        if (tc_dec) begin
            tc_d = tc_q - 16'h0001;
            // in byte-count mode the transfer ends with its last logical block
            if (bcm && tc_q == 16'h0001) begin
                state_d = st_idle;
            end
        end
        if (xfer_stop_i && state_q != st_idle) begin
            state_d = st_idle;
        end
        if (wr && avs_address_i == `LRC_OFS_CONTROL) begin
            if (avs_writedata_i[`LRC_CTL_LD]) begin
                tc_d[15:8] = avs_writedata_i[31:24];
            end
            if (avs_writedata_i[`LRC_CTL_LDL]) begin
                tc_d[7:0] = avs_writedata_i[23:16];
            end
        end
        if (sw_res_load) begin
            preset_d = 1'b1;
        end
        if (pipe_clear) begin
            state_d  = st_idle;
            out_v_d  = 1'b0;
            res_seed = 1'b1;
            preset_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= st_idle;
            dir_q      <= 1'b0;
            out_v_q    <= 1'b0;
            out_data_q <= '0;
            log_q      <= 1'b0;
            preset_q   <= 1'b0;
            tc_q       <= 16'h0000;
        end else begin
            state_q    <= state_d;
            dir_q      <= dir_d;
            out_v_q    <= out_v_d;
            out_data_q <= out_data_d;
            log_q      <= log_d;
            preset_q   <= preset_d;
            tc_q       <= tc_d;
        end
    end

    lrc_residue #(.W(W)) u_scsi_res (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .seed_i     (res_seed),
        .load_i     (sw_res_load),
        .load_val_i (avs_writedata_i[W-1:0]),
        .xor_i      (res_xor),
        .word_i     (in_data),
        .value_o    (res)
    );

    lrc_block_counter u_scsi_cnt (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .clear_i    (pipe_clear),
        .start_i    (cnt_start),
        .step_i     (cnt_step),
        .blk_size_i (blksize_q),
        .ratio_i    (ratio_q),
        .blk_last_o (blk_last),
        .log_last_o (log_last)
    );

    assign scsi_rx_ready_o = !dir_q && in_ready;
    assign fifo_rd_ready_o = dir_q && in_ready;
    assign fifo_wr_valid_o = !dir_q && out_v_q;
    assign scsi_tx_valid_o = dir_q && out_v_q;
    assign fifo_wr_data_o  = out_data_q;
    assign scsi_tx_data_o  = out_data_q;
    assign xfer_busy_o     = state_q != st_idle;
    assign xfer_halted_o   = state_q == st_halt;

    ////////////////////////////////////////////////////////////////////////
    // disk write checker: the word after each physical block is its check word
    logic dchk_q, dchk_d, dlog_q, dlog_d, dseed, dxor, dstep, dblk_last, dlog_last;

    always_comb begin
        dchk_d   = dchk_q;
        dlog_d   = dlog_q;
        dseed    = 1'b0;
        dxor     = 1'b0;
        dstep    = 1'b0;
        dmis_set = 1'b0;
        if (disk_start_i) begin
            dchk_d = 1'b0;
        end else if (disk_valid_i) begin
            if (dchk_q) begin
                dmis_set = disk_data_i != dres;
                dseed    = dlog_q;
                dchk_d   = 1'b0;
            end else begin
                dxor  = 1'b1;
                dstep = 1'b1;
                if (dblk_last) begin
                    dchk_d = 1'b1;
                    dlog_d = dlog_last;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dchk_q <= 1'b0;
            dlog_q <= 1'b0;
        end else begin
            dchk_q <= dchk_d;
            dlog_q <= dlog_d;
        end
    end

    lrc_residue #(.W(W)) u_disk_res (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .seed_i     (dseed),
        .load_i     (disk_start_i),
        .load_val_i (dpreset_q),
        .xor_i      (dxor),
        .word_i     (disk_data_i),
        .value_o    (dres)
    );

    lrc_block_counter u_disk_cnt (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .clear_i    (1'b0),
        .start_i    (disk_start_i),
        .step_i     (dstep),
        .blk_size_i (blksize_q),
        .ratio_i    (ratio_q),
        .blk_last_o (dblk_last),
        .log_last_o (dlog_last)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_insert_word: assert property (
        (state_q == st_insert && can_load && !pipe_clear && !xfer_stop_i)
        |=> out_v_q && out_data_q == $past(res)
            && state_q == ($past(log_q && bcm && tc_q == 16'h0001) ? st_idle : st_xfer))
        else $error("check word not pushed after block");
    chk_strip_reseed: assert property (
        (state_q == st_strip && in_fire && log_q && !(cce && in_data != res) && !sw_res_load)
        |=> res == `LRC_SEED)
        else $error("residue not reseeded at logical end");
    chk_mismatch_halt: assert property (
        (state_q == st_strip && in_fire && cce && in_data != res && !xfer_stop_i && !pipe_clear)
        |=> mis_q && xfer_halted_o)
        else $error("mismatch did not flag and halt");
    chk_nogen_no_strip: assert property (
        (state_q == st_xfer && !gen && !pipe_clear) |=> state_q != st_strip && state_q != st_insert)
        else $error("strip or insert without generation");
    chk_start_seed: assert property (
        (state_q == st_idle && xfer_start_i && !preset_q && !sw_res_load) |=> res == `LRC_SEED)
        else $error("residue not reseeded at start");
    chk_preset_keep: assert property (
        (state_q == st_idle && xfer_start_i && preset_q && !sw_res_load && !pipe_clear)
        |=> res == $past(res) && !preset_q)
        else $error("written residue lost at start");
    chk_pipe_clear: assert property (
        pipe_clear |=> state_q == st_idle && !out_v_q && res == `LRC_SEED)
        else $error("pipeline not cleared");
    chk_disk_reseed: assert property (
        (disk_valid_i && !disk_start_i && dchk_q && dlog_q) |=> dres == `LRC_SEED && !dchk_q)
        else $error("disk residue not reseeded");
    chk_disk_error: assert property (
        (disk_valid_i && !disk_start_i && dchk_q && disk_data_i != dres) |=> disk_mismatch_o)
        else $error("disk mismatch not flagged");
endmodule : lrc_block_checker

/* verification/lrc_far_model.sv */
// lrc_far_model: buffer side and scsi initiator facing the check block
// assumes: bench clock; the bench fills src_q and reads wr_q and tx_q
module lrc_far_model (
    input  wire logic        clk_i,
    input  wire logic        wr_valid_i,
    input  wire logic [15:0] wr_data_i,
    output logic             wr_ready_o,
    input  wire logic        tx_valid_i,
    input  wire logic [15:0] tx_data_i,
    output logic             tx_ready_o,
    output logic             rd_valid_o,
    output logic      [15:0] rd_data_o,
    input  wire logic        rd_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] wr_q[$], tx_q[$], src_q[$];
    initial begin
        wr_ready_o = 0;
        tx_ready_o = 0;
        rd_valid_o = 0;
        rd_data_o = 16'h0;
    end
    always @(posedge clk_i) begin
        if (wr_valid_i && wr_ready_o) wr_q.push_back(wr_data_i);
        if (tx_valid_i && tx_ready_o) tx_q.push_back(tx_data_i);
        if (rd_valid_o && rd_ready_i) void'(src_q.pop_front());
        // stall about one cycle in four so the output stage must hold
        wr_ready_o <= ($urandom % 4) != 0;
        tx_ready_o <= ($urandom % 4) != 0;
        rd_valid_o <= src_q.size() != 0;
        // an empty buffer leaves no stale word on the lines
        rd_data_o <= src_q.size() != 0 ? src_q[0] : ~rd_data_o;
    end
endmodule : lrc_far_model

/* verification/lrc_block_checker_tb.sv */
// lrc_block_checker_tb: receive, send, disk and register checks of the check block
// assumes: register map of lrc_params.svh, 16-bit words, one clock
`include "lrc_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module lrc_block_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, nrst = 0, rd = 0, wr = 0, start = 0, dir = 0, stop = 0;
    logic        rxv = 0, dv = 0, dst = 0;
    logic [4:0]  addr = 0;
    logic [31:0] wd = 0, ard, q;
    logic [15:0] rxd = 0, dd = 0, fwd, txd, frd, w[4];
    logic        wreq, busy, halted, rxr, fwv, fwr, frv, frr, txv, txr, dmis;
    int          errors = 0, samples_checked = 0;
    always #5 clk = ~clk;
    lrc_block_checker u_dut (.core_clk_i(clk), .nrst_i(nrst), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(ard), .avs_waitrequest_o(wreq),
        .xfer_start_i(start), .xfer_dir_i(dir), .xfer_stop_i(stop), .xfer_busy_o(busy),
        .xfer_halted_o(halted), .scsi_rx_valid_i(rxv), .scsi_rx_data_i(rxd), .scsi_rx_ready_o(rxr),
        .fifo_wr_valid_o(fwv), .fifo_wr_data_o(fwd), .fifo_wr_ready_i(fwr), .fifo_rd_valid_i(frv),
        .fifo_rd_data_i(frd), .fifo_rd_ready_o(frr), .scsi_tx_valid_o(txv), .scsi_tx_data_o(txd),
        .scsi_tx_ready_i(txr), .disk_start_i(dst), .disk_valid_i(dv), .disk_data_i(dd),
        .disk_mismatch_o(dmis));
    lrc_far_model u_far (.clk_i(clk), .wr_valid_i(fwv), .wr_data_i(fwd), .wr_ready_o(fwr),
        .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr), .rd_valid_o(frv), .rd_data_o(frd),
        .rd_ready_i(frr));
    ////////////////////////////////////////////////////////////////////////////
    task automatic av(input logic we, input logic [4:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        rd <= !we; wr <= we; addr <= a; wd <= d;
        do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) errors++;
        q = ard;
        rd <= 0; wr <= 0;
    endtask : av
    task automatic kick(input int k, input logic d);
        @(posedge clk);
        start <= k == 0; stop <= k == 1; dst <= k == 2; dir <= d;
        @(posedge clk);
        start <= 0; stop <= 0; dst <= 0;
    endtask : kick
    task automatic rx_send(input int k);
        for (int i = 0; i < k; i++) begin
            rxv <= 1; rxd <= w[i];
            do @(posedge clk); while (rxr !== 1'b1);
        end
        rxv <= 0; rxd <= ~rxd;
    endtask : rx_send
    task automatic disk3(input logic [15:0] a, b, c);
        @(posedge clk);
        dv <= 1; dd <= a; @(posedge clk); dd <= b; @(posedge clk); dd <= c; @(posedge clk);
        dv <= 0; dd <= ~c; repeat (3) @(negedge clk);
    endtask : disk3
    task automatic settle(input int k);
        for (int n = 0; n < 200 && u_far.wr_q.size() + u_far.tx_q.size() < k; n++) @(posedge clk);
        repeat (6) @(negedge clk);
    endtask : settle
    function automatic logic [15:0] lrc_of(input logic [15:0] s, input int k);
        lrc_of = s;
        for (int i = 0; i < k; i++) lrc_of ^= w[i];
    endfunction : lrc_of
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        #300us;
        errors++;
        close_out;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(73117));
        repeat (8) @(posedge clk);
        nrst <= 1;
        av(0, `LRC_OFS_RATIO, 0); `CHK(q, 32'h0)
        av(0, `LRC_OFS_BLKSIZE, 0); `CHK(q[15:0], 16'h01ff)
        av(0, 5'h1e, 0); `CHK(q, 32'h0)
        $display("test registers done");
        av(1, `LRC_OFS_BLKSIZE, 32'h3);
        for (int t = 0; t < 3; t++) begin
            logic [15:0] s;
            s = t == 1 ? 16'h1357 : `LRC_SEED;
            foreach (w[i]) w[i] = 16'($urandom);
            av(1, `LRC_OFS_RATIO, t == 2 ? 32'h13 : 32'h0);
            av(1, `LRC_OFS_CONFIG, 32'h5);
            av(1, `LRC_OFS_CONTROL, 32'h0001_0002);
            if (t == 1) av(1, `LRC_OFS_RESIDUE, s);
            kick(0, 0); rx_send(t == 2 ? 4 : 2); settle(t == 2 ? 6 : 3);
            `CHK(u_far.wr_q[1], w[1])
            `CHK(u_far.wr_q[2], lrc_of(s, 2))
            if (t == 2) `CHK(u_far.wr_q[5], lrc_of(s, 4))
            `CHK(busy, 1'b0)
            u_far.wr_q.delete();
        end
        $display("test receive done");
        av(1, `LRC_OFS_RATIO, 0);
        for (int t = 0; t < 3; t++) begin
            foreach (w[i]) w[i] = 16'($urandom);
            u_far.src_q = '{w[0], w[1], lrc_of(`LRC_SEED, 2) ^ 16'(t == 1)};
            av(1, `LRC_OFS_CONFIG, t == 2 ? 32'h4 : 32'h7);
            av(1, `LRC_OFS_CONTROL, 32'h0001_0002);
            kick(0, 1); settle(t == 2 ? 3 : 2);
            `CHK(u_far.tx_q.size(), t == 2 ? 3 : 2)
            `CHK(u_far.tx_q[1], w[1])
            `CHK(halted, t == 1)
            av(0, `LRC_OFS_STATUS, 0); `CHK(q[0], t == 1)
            av(1, `LRC_OFS_STATUS, 32'h1); kick(1, 0);
            u_far.tx_q.delete();
        end
        $display("test send done");
        foreach (w[i]) w[i] = 16'($urandom);
        av(1, `LRC_OFS_DPRESET, 32'h1357); kick(2, 0);
        disk3(w[0], w[1], lrc_of(16'h1357, 2)); `CHK(dmis, 1'b0)
        disk3(w[2], w[3], `LRC_SEED ^ w[2] ^ w[3]); `CHK(dmis, 1'b0)
        disk3(w[0], w[1], ~lrc_of(`LRC_SEED, 2)); `CHK(dmis, 1'b1)
        $display("test disk done");
        av(1, `LRC_OFS_RESIDUE, 32'h2468); av(1, `LRC_OFS_CONTROL, 32'h3);
        av(0, `LRC_OFS_RESIDUE, 0); `CHK(q[15:0], `LRC_SEED)
        $display("test clear done");
        close_out;
    end
endmodule : lrc_block_checker_tb
